// ---- src/fasm_addr_map.sv ----
// address width control and sector map lookup
// Functional notes
// - with extended mode off, legacy commands take three address bytes.
// - volatile extended mode bit makes legacy commands take four address bytes.
// - four-byte commands always take four address bytes.
// - extended mode bit clears at reset, then loads from non-volatile default on the first clock after reset.
// - other address spaces still receive full width address for the mode.
// - main array erase sectors are 256 KB except parameter sectors and the 224 KB sector.
// - low die allows bottom or uniform, high die top or uniform.
// - only bottom, top or uniform overall maps are supported.
// - bottom map: eight 4 KB, one 224 KB, then 511 of 256 KB.
// - top map: 511 of 256 KB, one 224 KB, eight 4 KB at top.
// - uniform map: 512 sectors of 256 KB across 128 MB.
// - each 4 KB sector is aligned on its low twelve bits.
`timescale 1ns/1ps
`include "fasm_regs.svh"
module fasm_addr_map
  import fasm_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    nv_ext_addr_default,
  input  wire logic                    ext_addr_wr,
  input  wire logic                    ext_addr_wdata,
  input  wire fasm_pkg::fasm_die_cfg_t low_die_cfg,
  input  wire fasm_pkg::fasm_die_cfg_t high_die_cfg,
  input  wire fasm_pkg::fasm_req_t     req,
  output logic                         ext_addr_mode,
  output logic [2:0]                   addr_bytes,
  output fasm_pkg::fasm_map_t          active_map,
  output logic                         map_error,
  output fasm_pkg::fasm_sect_t         sect_out,
  output logic                         sect_in_main
);
  import fasm_pkg::*;

  logic                ext_q;
  logic                ext_d;
  logic                loaded_q;
  logic                loaded_d;
  logic [2:0]          bytes_q;
  logic [2:0]          bytes_d;
  fasm_map_t           map_q;
  fasm_map_t           map_d;
  logic                err_q;
  logic                err_d;
  fasm_sect_t          sect_q;
  fasm_sect_t          sect_d;
  logic                main_q;
  logic                main_d;
  fasm_sect_t          dec;
  logic [31:0]         eff_addr;

  function automatic fasm_map_t combine(input fasm_die_cfg_t lo, input fasm_die_cfg_t hi);
    fasm_map_t m;
    m = FASM_MAP_NONE;
    if (lo == FASM_DIE_UNIFORM && hi == FASM_DIE_UNIFORM)
      m = FASM_MAP_UNIFORM;
    else if (lo == FASM_DIE_BOTTOM && hi == FASM_DIE_UNIFORM)
      m = FASM_MAP_BOTTOM;
    else if (lo == FASM_DIE_UNIFORM && hi == FASM_DIE_TOP)
      m = FASM_MAP_TOP;
    return m;
  endfunction

  function automatic logic [2:0] width_of(input logic four_cmd, input logic ext);
    return (four_cmd || ext) ? `FASM_ADDR4_BYTES : `FASM_ADDR3_BYTES;
  endfunction

  // extended mode state and address width
  always_comb
  begin
    loaded_d = 1'b1;
    ext_d    = ext_q;
    if (!loaded_q)
      ext_d = nv_ext_addr_default;
    else if (ext_addr_wr)
      ext_d = ext_addr_wdata;
    bytes_d = width_of(1'b0, ext_d);
    if (req.valid)
      bytes_d = width_of(req.four_byte_cmd, ext_q);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_q    <= 1'b0;
      loaded_q <= 1'b0;
      bytes_q  <= `FASM_ADDR3_BYTES;
    end
    else
    begin
      ext_q    <= ext_d;
      loaded_q <= loaded_d;
      bytes_q  <= bytes_d;
    end
  end

  // die configuration check
  always_comb
  begin
    map_d = combine(low_die_cfg, high_die_cfg);
    err_d = (map_d == FASM_MAP_NONE);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      map_q <= FASM_MAP_UNIFORM;
      err_q <= 1'b0;
    end
    else
    begin
      map_q <= map_d;
      err_q <= err_d;
    end
  end

  // address masking and sector lookup
  always_comb
  begin
    eff_addr = req.addr;
    if (!(req.four_byte_cmd || ext_q))
      eff_addr = {8'h00, req.addr[23:0]};
  end

  fasm_sector_decode u_dec
  (
    .map  (map_q),
    .addr (eff_addr),
    .sect (dec)
  );

  always_comb
  begin
    sect_d = sect_q;
    main_d = main_q;
    if (req.valid)
    begin
      sect_d       = dec;
      sect_d.valid = dec.valid && req.main_array;
      main_d       = req.main_array;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sect_q <= '0;
      main_q <= 1'b0;
    end
    else
    begin
      sect_q <= sect_d;
      main_q <= main_d;
    end
  end

  assign ext_addr_mode = ext_q;
  assign addr_bytes    = bytes_q;
  assign active_map    = map_q;
  assign map_error     = err_q;
  assign sect_out      = sect_q;
  assign sect_in_main  = main_q;

  // checks
  ext_load_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(loaded_q) |-> ext_q == $past(nv_ext_addr_default)) else $error("ext mode not loaded");
  four_cmd_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.four_byte_cmd |=> addr_bytes == 3'h4) else $error("four byte cmd width");
  legacy3_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && !req.four_byte_cmd && !ext_q |=> addr_bytes == 3'h3) else $error("legacy width");
  legacy4_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && !req.four_byte_cmd && ext_q |=> addr_bytes == 3'h4) else $error("ext width");
  die_combo_a: assert property (@(posedge clock) disable iff (!arst_n)
    low_die_cfg != FASM_DIE_UNIFORM && high_die_cfg != FASM_DIE_UNIFORM |=> map_error) else $error("bad die combo");
  map_err_a: assert property (@(posedge clock) disable iff (!arst_n)
    map_error |-> active_map == FASM_MAP_NONE) else $error("map error");
  param_align_a: assert property (@(posedge clock) disable iff (!arst_n)
    sect_out.valid && sect_out.sector_end - sect_out.sector_base == 32'h00000FFF
    |-> sect_out.sector_base[11:0] == 12'h000) else $error("param align");
  bot_param_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.main_array && map_q == FASM_MAP_BOTTOM && eff_addr <= 32'h00007FFF
    |=> sect_out.sector_index == {7'h00, $past(eff_addr[14:12])}) else $error("bottom param idx");
  top_mid_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.main_array && map_q == FASM_MAP_TOP && eff_addr >= 32'h07FC0000 && eff_addr < 32'h07FF8000
    |=> sect_out.sector_index == 10'h1FF) else $error("top mid idx");
  uni_idx_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.main_array && map_q == FASM_MAP_UNIFORM
    |=> sect_out.sector_index == $past(eff_addr[27:18])) else $error("uniform idx");
  big_size_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.main_array && map_q == FASM_MAP_UNIFORM
    |=> sect_out.sector_end - sect_out.sector_base == 32'h0003FFFF) else $error("sector size");
  main_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid |=> sect_in_main == $past(req.main_array)) else $error("space flag");
endmodule

// ---- src/fasm_pkg.sv ----
// types for the flash address and sector map block
package fasm_pkg;
  typedef enum logic [1:0] {FASM_DIE_UNIFORM, FASM_DIE_BOTTOM, FASM_DIE_TOP, FASM_DIE_BAD} fasm_die_cfg_t;
  typedef enum logic [1:0] {FASM_MAP_UNIFORM, FASM_MAP_BOTTOM, FASM_MAP_TOP, FASM_MAP_NONE} fasm_map_t;
  typedef struct packed {
    logic        valid;
    logic        four_byte_cmd;
    logic        main_array;
    logic [31:0] addr;
  } fasm_req_t;
  typedef struct packed {
    logic        valid;
    logic        in_range;
    logic [9:0]  sector_index;
    logic [31:0] sector_base;
    logic [31:0] sector_end;
  } fasm_sect_t;
endpackage

// ---- src/fasm_regs.svh ----
// constants for the flash address and sector map block
`ifndef FASM_REGS_SVH
`define FASM_REGS_SVH
`define FASM_ADDR3_BYTES    3'h3
`define FASM_ADDR4_BYTES    3'h4
`define FASM_PARAM_SEC_BITS 12
`define FASM_BIG_SEC_BITS   18
`define FASM_PARAM_COUNT    10'h008
`define FASM_BIG_COUNT      10'h200
`define FASM_ARRAY_TOP      32'h07FFFFFF
`define FASM_TOP_BIG_BASE   32'h07FC0000
`define FASM_TOP_PARAM_BASE 32'h07FF8000
`define FASM_BOT_PARAM_END  32'h00007FFF
`define FASM_BOT_BIG_END    32'h0003FFFF
`define FASM_TOP_MID_IDX    10'h1FF
`define FASM_BOT_MID_IDX    10'h008
`define FASM_TOP_PARAM_IDX  10'h200
`define FASM_BOT_BIG_OFS    10'h008
`endif

// ---- src/fasm_sector_decode.sv ----
// sector decoder: byte address to sector index and bounds
`timescale 1ns/1ps
`include "fasm_regs.svh"
module fasm_sector_decode
  import fasm_pkg::*;
(
  input  wire fasm_pkg::fasm_map_t  map,
  input  wire logic [31:0]          addr,
  output fasm_pkg::fasm_sect_t      sect
);
  logic [31:0] big_base;
  logic [31:0] prm_base;
  logic [9:0]  big_idx;
  logic [9:0]  prm_idx;

  always_comb
  begin
    big_base = {addr[31:`FASM_BIG_SEC_BITS], 18'h00000};
    prm_base = {addr[31:`FASM_PARAM_SEC_BITS], 12'h000};
    big_idx  = addr[27:18];
    prm_idx  = {7'h00, addr[14:12]};
    sect.valid        = (map != FASM_MAP_NONE);
    sect.in_range     = (addr <= `FASM_ARRAY_TOP);
    sect.sector_index = big_idx;
    sect.sector_base  = big_base;
    sect.sector_end   = big_base | 32'h0003FFFF;
    case (map)
      FASM_MAP_BOTTOM:
      begin
        if (addr <= `FASM_BOT_PARAM_END)
        begin
          sect.sector_index = prm_idx;
          sect.sector_base  = prm_base;
          sect.sector_end   = prm_base | 32'h00000FFF;
        end
        else if (addr <= `FASM_BOT_BIG_END)
        begin
          sect.sector_index = `FASM_BOT_MID_IDX;
          sect.sector_base  = 32'h00008000;
          sect.sector_end   = `FASM_BOT_BIG_END;
        end
        else
          sect.sector_index = big_idx + `FASM_BOT_BIG_OFS;
      end
      FASM_MAP_TOP:
      begin
        if (addr >= `FASM_TOP_PARAM_BASE && addr <= `FASM_ARRAY_TOP)
        begin
          sect.sector_index = `FASM_TOP_PARAM_IDX + prm_idx;
          sect.sector_base  = prm_base;
          sect.sector_end   = prm_base | 32'h00000FFF;
        end
        else if (addr >= `FASM_TOP_BIG_BASE && addr <= `FASM_ARRAY_TOP)
        begin
          sect.sector_index = `FASM_TOP_MID_IDX;
          sect.sector_base  = `FASM_TOP_BIG_BASE;
          sect.sector_end   = `FASM_TOP_PARAM_BASE - 32'h00000001;
        end
      end
      FASM_MAP_UNIFORM:
        sect.sector_index = big_idx;
      default:
        sect.sector_index = 10'h000;
    endcase
  end
endmodule

// ---- test/fasm_addr_map_tb.sv ----
// testbench for the address width and sector map block
`timescale 1ns/1ps
module fasm_addr_map_tb;
  import fasm_pkg::*;
  typedef struct {
    fasm_map_t   map;
    logic        four;
    logic        main;
    logic [31:0] addr;
    logic        valid;
    logic [9:0]  idx;
    logic [31:0] base;
    logic [31:0] last;
  } fasm_row_t;
  logic                clock = 0;
  logic                arst_n = 0;
  logic                nv_def = 0;
  logic                wr = 0;
  logic                wdata = 0;
  fasm_map_t           want_map = FASM_MAP_UNIFORM;
  logic                break_pair = 0;
  logic                go = 0;
  logic                four = 0;
  logic                main = 0;
  logic [31:0]         addr = 32'h0;
  fasm_die_cfg_t       low_cfg;
  fasm_die_cfg_t       high_cfg;
  fasm_req_t           req;
  logic                ext_mode;
  logic [2:0]          addr_bytes;
  fasm_map_t           active_map;
  logic                map_error;
  fasm_sect_t          sect;
  logic                in_main;
  int                  err_total = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  fasm_row_t           rows[12];
  always #50 clock = ~clock;
  fasm_host_model host (.ext_mode(ext_mode), .want_map(want_map), .break_pair(break_pair), .go(go),
    .four(four), .main(main), .addr(addr), .low_die_cfg(low_cfg), .high_die_cfg(high_cfg), .req(req));
  fasm_addr_map uut (.clock(clock), .arst_n(arst_n), .nv_ext_addr_default(nv_def), .ext_addr_wr(wr),
    .ext_addr_wdata(wdata), .low_die_cfg(low_cfg), .high_die_cfg(high_cfg), .req(req),
    .ext_addr_mode(ext_mode), .addr_bytes(addr_bytes), .active_map(active_map), .map_error(map_error),
    .sect_out(sect), .sect_in_main(in_main));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%h got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic f, input logic m, input logic [31:0] a);
    go = 1;
    four = f;
    main = m;
    addr = a;
    @(negedge clock);
    go = 0;
  endtask
  task automatic set_map(input fasm_map_t m, input logic brk);
    want_map = m;
    break_pair = brk;
    @(negedge clock);
    @(negedge clock);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    rows = '{
      '{FASM_MAP_UNIFORM, 1, 1, 32'h00000000, 1, 10'h000, 32'h00000000, 32'h0003FFFF},
      '{FASM_MAP_UNIFORM, 1, 1, 32'h07FFFFFF, 1, 10'h1FF, 32'h07FC0000, 32'h07FFFFFF},
      '{FASM_MAP_UNIFORM, 0, 1, 32'h5A001234, 1, 10'h000, 32'h00000000, 32'h0003FFFF},
      '{FASM_MAP_BOTTOM, 1, 1, 32'h00007123, 1, 10'h007, 32'h00007000, 32'h00007FFF},
      '{FASM_MAP_BOTTOM, 1, 1, 32'h00008000, 1, 10'h008, 32'h00008000, 32'h0003FFFF},
      '{FASM_MAP_BOTTOM, 0, 1, 32'h00040000, 1, 10'h009, 32'h00040000, 32'h0007FFFF},
      '{FASM_MAP_BOTTOM, 1, 1, 32'h07FFFFFF, 1, 10'h207, 32'h07FC0000, 32'h07FFFFFF},
      '{FASM_MAP_TOP, 1, 1, 32'h07F80000, 1, 10'h1FE, 32'h07F80000, 32'h07FBFFFF},
      '{FASM_MAP_TOP, 1, 1, 32'h07FC0000, 1, 10'h1FF, 32'h07FC0000, 32'h07FF7FFF},
      '{FASM_MAP_TOP, 1, 1, 32'h07FF8ABC, 1, 10'h200, 32'h07FF8000, 32'h07FF8FFF},
      '{FASM_MAP_TOP, 1, 1, 32'h07FFFFFF, 1, 10'h207, 32'h07FFF000, 32'h07FFFFFF},
      '{FASM_MAP_TOP, 1, 0, 32'h00000010, 0, 10'h000, 32'h0, 32'h0}};
    repeat (4) @(negedge clock);
    arst_n = 1;
    @(negedge clock);
    foreach (rows[i])
    begin
      set_map(rows[i].map, 0);
      chk(active_map, rows[i].map);
      chk(map_error, 1'b0);
      issue(rows[i].four, rows[i].main, rows[i].addr);
      chk(addr_bytes, rows[i].four ? 3'h4 : 3'h3);
      chk(in_main, rows[i].main);
      chk(sect.valid, rows[i].valid);
      if (rows[i].valid)
      begin
        chk(sect.in_range, 1'b1);
        chk(sect.sector_index, rows[i].idx);
        chk(sect.sector_base, rows[i].base);
        chk(sect.sector_end, rows[i].last);
      end
    end
    set_map(FASM_MAP_BOTTOM, 1);
    chk(map_error, 1'b1);
    chk(active_map, FASM_MAP_NONE);
    issue(1, 1, 32'h00001000);
    chk(sect.valid, 1'b0);
    set_map(FASM_MAP_UNIFORM, 0);
    wr = 1;
    wdata = 1;
    @(negedge clock);
    wr = 0;
    chk(ext_mode, 1'b1);
    issue(0, 1, 32'h01000000);
    chk(addr_bytes, 3'h4);
    chk(sect.sector_index, 10'h040);
    issue(1, 1, 32'h08000000);
    chk(sect.in_range, 1'b0);
    arst_n = 0;
    nv_def = 1;
    @(negedge clock);
    chk(ext_mode, 1'b0);
    chk(addr_bytes, 3'h3);
    arst_n = 1;
    @(negedge clock);
    chk(ext_mode, 1'b1);
    issue(0, 0, 32'h00000020);
    chk(addr_bytes, 3'h4);
    chk(sect.valid, 1'b0);
    wrap_up();
  end
endmodule

// ---- test/fasm_host_model.sv ----
// host controller model: die setup and request framing
`timescale 1ns/1ps
module fasm_host_model
  import fasm_pkg::*;
(
  input  wire logic                ext_mode,
  input  wire fasm_pkg::fasm_map_t want_map,
  input  wire logic                break_pair,
  input  wire logic                go,
  input  wire logic                four,
  input  wire logic                main,
  input  wire logic [31:0]         addr,
  output fasm_pkg::fasm_die_cfg_t  low_die_cfg,
  output fasm_pkg::fasm_die_cfg_t  high_die_cfg,
  output fasm_pkg::fasm_req_t      req
);
  always_comb
  begin
    req.valid = go;
    req.four_byte_cmd = four;
    req.main_array = main;
    // unsent high byte shows a changed pattern
    req.addr = (four || ext_mode) ? addr : {~addr[31:24], addr[23:0]};
    low_die_cfg = (want_map == FASM_MAP_BOTTOM) ? FASM_DIE_BOTTOM : FASM_DIE_UNIFORM;
    high_die_cfg = (want_map == FASM_MAP_TOP || break_pair) ? FASM_DIE_TOP : FASM_DIE_UNIFORM;
  end
endmodule
